/* File: srv_regs.sv */
// Register bank for VCO overrides, reference path, dividers and charge pump mode.
// Assumes calibration enables and the frequency calibration write strobe come from same-clock logic.
`timescale 1ns/1ps

// Notes on behaviour
// - Amplitude override bit 13 bypasses amplitude calibration
// - Capbank override bit 10 bypasses frequency calibration
// - Bit 11 enables the reference doubler
// - Bit 9 enables reference path, reset one
// - Multiplier factor in bits 11:7
// - Post divider bits 11:4, reset one
// - Pre divider low field, reset one
// - Bit 14 enables charge pump, reset one
// - Detector mode: 0 dual, 3 single
// - Frequency calibration start blocked by capbank override
// - Amplitude calibration enable runs amplitude algorithm
module srv_regs (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_spi_csb_n,
  input  wire logic                 i_spi_sck,
  input  wire logic                 i_spi_sdi,
  output logic                      o_spi_sdo,
  input  wire logic                 i_amplitude_cal_enable,
  input  wire logic                 i_frequency_cal_write,
  output logic                      o_amplitude_override,
  output logic                      o_capbank_override,
  output logic                      o_amplitude_cal_run,
  output logic                      o_frequency_cal_start,
  output srv_pkg::srv_ref_path_t    o_ref_path,
  output logic                      o_charge_pump_enable,
  output logic [1:0]                o_detector_mode,
  output logic                      o_detector_single
);
  import srv_pkg::*;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] rel;
    rel = addr - OFF_VCO_OVERRIDE_CTRL;
    return rel[2:0];
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    return addr >= OFF_VCO_OVERRIDE_CTRL && addr <= OFF_CHARGE_PUMP_CTRL;
  endfunction

  function automatic logic [DATA_W-1:0] reset_value(input int unsigned idx);
    case (idx)
      0:       return RST_VCO_OVERRIDE_CTRL;
      1:       return RST_REFERENCE_PATH_CTRL;
      2:       return RST_REFERENCE_MULTIPLIER_FACTOR_CFG;
      3:       return RST_REFERENCE_POST_CFG;
      4:       return RST_REFERENCE_PRE_CFG;
      default: return RST_CHARGE_PUMP_CTRL;
    endcase
  endfunction

  // ----------------------------------------
  // Serial port
  // ----------------------------------------
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  srv_wr_t           wr;
  logic              wr_valid;
  logic [DATA_W-1:0] regs_q [REG_COUNT];

  srv_serial_port u_port (
    .i_clk_sys   (i_clk_sys),
    .i_rst_n     (i_rst_n),
    .i_spi_csb_n (i_spi_csb_n),
    .i_spi_sck   (i_spi_sck),
    .i_spi_sdi   (i_spi_sdi),
    .o_spi_sdo   (o_spi_sdo),
    .o_rd_addr   (rd_addr),
    .i_rd_data   (rd_data),
    .o_wr        (wr),
    .o_wr_valid  (wr_valid)
  );

  // Unmapped addresses read zero and drop writes
  assign rd_data = is_mapped(rd_addr) ? regs_q[reg_index(rd_addr)] : RD_UNMAPPED;

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  // Undocumented bits are stored as written; the host owns their values
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_q[i] <= reset_value(i);
      end
    end else if (wr_valid && is_mapped(wr.addr)) begin
      regs_q[reg_index(wr.addr)] <= wr.data;
    end
  end

  // ----------------------------------------
  // Analog controls
  // ----------------------------------------
  logic [DATA_W-1:0] vco_r, ref_r, multiplier_factor_r, post_r, pre_r, cp_r;

  assign vco_r  = regs_q[0];
  assign ref_r  = regs_q[1];
  assign multiplier_factor_r = regs_q[2];
  assign post_r = regs_q[3];
  assign pre_r  = regs_q[4];
  assign cp_r   = regs_q[5];

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_amplitude_override <= 1'b0;
      o_capbank_override   <= 1'b0;
      o_ref_path           <= '0;
      o_charge_pump_enable <= 1'b0;
      o_detector_mode      <= DETECTOR_DUAL;
      o_detector_single    <= 1'b0;
    end else begin
      o_amplitude_override <= vco_r[POS_AMPLITUDE_OVERRIDE];
      o_capbank_override   <= vco_r[POS_CAPBANK_OVERRIDE];
      o_ref_path.reference_doubler_enable <= ref_r[POS_DOUBLER_ENABLE];
      o_ref_path.reference_enable         <= ref_r[POS_REFERENCE_ENABLE];
      o_ref_path.multiplier_factor        <= multiplier_factor_r[POS_MULTIPLIER_FACTOR_LSB +: MULTIPLIER_FACTOR_W];
      o_ref_path.post_divide              <= post_r[POS_POST_DIV_LSB +: POST_DIV_W];
      o_ref_path.pre_divide               <= pre_r[POS_PRE_DIV_LSB +: PRE_DIV_W];
      o_charge_pump_enable <= cp_r[POS_CHARGE_PUMP_ENABLE];
      o_detector_mode      <= cp_r[POS_DETECTOR_MODE_LSB +: DETECTOR_MODE_W];
      // Codes 1 and 2 are undefined; only 3 leaves dual mode
      o_detector_single    <= cp_r[POS_DETECTOR_MODE_LSB +: DETECTOR_MODE_W] == DETECTOR_SINGLE;
    end
  end

  // ----------------------------------------
  // Calibration gating
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_amplitude_cal_run   <= 1'b0;
      o_frequency_cal_start <= 1'b0;
    end else begin
      o_amplitude_cal_run   <= i_amplitude_cal_enable && !vco_r[POS_AMPLITUDE_OVERRIDE];
      // Start is a strobe; a held enable would retrigger calibration
      o_frequency_cal_start <= i_frequency_cal_write && !vco_r[POS_CAPBANK_OVERRIDE];
    end
  end

endmodule

/* File: srv_pkg.sv */
// Constants and types for the reference path and VCO override register slice.
// Assumes a 10 MHz system clock and a 24-bit serial frame: direction bit, 7-bit address, 16-bit data.
package srv_pkg;

  // ----------------------------------------
  // Frame and register geometry
  // ----------------------------------------
  localparam int unsigned ADDR_W     = 7;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned HEAD_BITS  = 8;
  localparam int unsigned REG_COUNT  = 6;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [6:0] OFF_VCO_OVERRIDE_CTRL   = 7'h08;
  localparam logic [6:0] OFF_REFERENCE_PATH_CTRL = 7'h09;
  localparam logic [6:0] OFF_REFERENCE_MULTIPLIER_FACTOR_CFG  = 7'h0a;
  localparam logic [6:0] OFF_REFERENCE_POST_CFG  = 7'h0b;
  localparam logic [6:0] OFF_REFERENCE_PRE_CFG   = 7'h0c;
  localparam logic [6:0] OFF_CHARGE_PUMP_CTRL    = 7'h0d;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned POS_AMPLITUDE_OVERRIDE   = 13;
  localparam int unsigned POS_CAPBANK_OVERRIDE     = 10;
  localparam int unsigned POS_DOUBLER_ENABLE       = 11;
  localparam int unsigned POS_REFERENCE_ENABLE     = 9;
  localparam int unsigned POS_MULTIPLIER_FACTOR_LSB             = 7;
  localparam int unsigned MULTIPLIER_FACTOR_W                   = 5;
  localparam int unsigned POS_POST_DIV_LSB         = 4;
  localparam int unsigned POST_DIV_W               = 8;
  localparam int unsigned POS_PRE_DIV_LSB          = 0;
  localparam int unsigned PRE_DIV_W                = 12;
  localparam int unsigned POS_CHARGE_PUMP_ENABLE   = 14;
  localparam int unsigned POS_DETECTOR_MODE_LSB    = 0;
  localparam int unsigned DETECTOR_MODE_W          = 2;

  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [15:0] RST_VCO_OVERRIDE_CTRL   = 16'h0000;
  localparam logic [15:0] RST_REFERENCE_PATH_CTRL = 16'h0200;
  localparam logic [15:0] RST_REFERENCE_MULTIPLIER_FACTOR_CFG  = 16'h0080;
  localparam logic [15:0] RST_REFERENCE_POST_CFG  = 16'h0010;
  localparam logic [15:0] RST_REFERENCE_PRE_CFG   = 16'h0001;
  localparam logic [15:0] RST_CHARGE_PUMP_CTRL    = 16'h4000;
  localparam logic [15:0] RD_UNMAPPED             = 16'h0000;

  localparam logic [1:0] DETECTOR_DUAL   = 2'h0;
  localparam logic [1:0] DETECTOR_SINGLE = 2'h3;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } srv_wr_t;

  typedef struct packed {
    logic                  reference_doubler_enable;
    logic                  reference_enable;
    logic [MULTIPLIER_FACTOR_W-1:0]     multiplier_factor;
    logic [POST_DIV_W-1:0] post_divide;
    logic [PRE_DIV_W-1:0]  pre_divide;
  } srv_ref_path_t;

endpackage

/* File: srv_serial_port.sv */
// Serial programming port: samples the frame pins and delivers whole register writes.
// Assumes pins are asynchronous to i_clk_sys and the serial clock is well below 5 MHz.
`timescale 1ns/1ps
module srv_serial_port (
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_spi_csb_n,
  input  wire logic                        i_spi_sck,
  input  wire logic                        i_spi_sdi,
  output logic                             o_spi_sdo,
  output logic [srv_pkg::ADDR_W-1:0]       o_rd_addr,
  input  wire logic [srv_pkg::DATA_W-1:0]  i_rd_data,
  output srv_pkg::srv_wr_t                 o_wr,
  output logic                             o_wr_valid
);
  import srv_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic       csb_meta_q, csb_q, csb_prev_q;
  logic       sck_meta_q, sck_q, sck_prev_q;
  logic       sdi_meta_q, sdi_q;
  logic       sck_rise, sck_fall, csb_rise;
  logic [4:0] bit_cnt_q;
  logic [FRAME_BITS-1:0] shift_q;
  logic [DATA_W-1:0]     rd_shift_q;
  logic                  head_done;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      csb_meta_q <= 1'b1;
      csb_q      <= 1'b1;
      csb_prev_q <= 1'b1;
      sck_meta_q <= 1'b0;
      sck_q      <= 1'b0;
      sck_prev_q <= 1'b0;
      sdi_meta_q <= 1'b0;
      sdi_q      <= 1'b0;
    end else begin
      csb_meta_q <= i_spi_csb_n;
      csb_q      <= csb_meta_q;
      csb_prev_q <= csb_q;
      sck_meta_q <= i_spi_sck;
      sck_q      <= sck_meta_q;
      sck_prev_q <= sck_q;
      sdi_meta_q <= i_spi_sdi;
      sdi_q      <= sdi_meta_q;
    end
  end

  assign sck_rise  = !csb_q && sck_q && !sck_prev_q;
  assign sck_fall  = !csb_q && !sck_q && sck_prev_q;
  assign csb_rise  = csb_q && !csb_prev_q;
  assign head_done = sck_rise && (bit_cnt_q == 5'(HEAD_BITS - 1));
  assign o_rd_addr = {shift_q[ADDR_W-2:0], sdi_q};

  // ----------------------------------------
  // Frame shifter
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      bit_cnt_q <= 5'h00;
      shift_q   <= 24'h00_0000;
    end else if (csb_q) begin
      bit_cnt_q <= 5'h00;
    end else if (sck_rise) begin
      shift_q <= {shift_q[FRAME_BITS-2:0], sdi_q};
      // Saturate so an overlong frame is refused, not wrapped
      if (bit_cnt_q <= 5'(FRAME_BITS))
        bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  // ----------------------------------------
  // Readback shifter
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rd_shift_q <= 16'h0000;
      o_spi_sdo  <= 1'b0;
    end else if (csb_q) begin
      o_spi_sdo <= 1'b0;
    end else if (head_done) begin
      rd_shift_q <= i_rd_data;
    end else if (sck_fall && bit_cnt_q >= 5'(HEAD_BITS)) begin
      o_spi_sdo  <= rd_shift_q[DATA_W-1];
      rd_shift_q <= {rd_shift_q[DATA_W-2:0], 1'b0};
    end
  end

  // ----------------------------------------
  // Write commit at frame end
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_wr_valid <= 1'b0;
      o_wr       <= '0;
    end else begin
      o_wr_valid <= csb_rise && bit_cnt_q == 5'(FRAME_BITS) && !shift_q[FRAME_BITS-1];
      if (csb_rise)
        o_wr <= {shift_q[FRAME_BITS-2:DATA_W], shift_q[DATA_W-1:0]};
    end
  end

endmodule

/* File: srv_host_model.sv */
// Host controller model driving the serial programming pins.
// Assumes a 10 MHz i_clk_sys; sck half period is five clocks.
`timescale 1ns/1ps
module srv_host_model (
  input  wire logic i_clk_sys,
  input  wire logic i_spi_sdo,
  output logic      o_spi_csb_n,
  output logic      o_spi_sck,
  output logic      o_spi_sdi
);
  initial begin
    o_spi_csb_n = 1'b1;
    o_spi_sck   = 1'b0;
    o_spi_sdi   = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  // Frame of n bits, MSB first; read bits taken just before each rise from bit 8 on
  task automatic xfer(input logic rw, input logic [6:0] a, input logic [15:0] d, input int n,
                      output logic [15:0] q);
    logic [23:0] f;
    f = {rw, a, d};
    q = 16'h0000;
    tick(1);
    o_spi_csb_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      o_spi_sdi = f[23-i];
      tick(5);
      if (i >= 8) q[23-i] = i_spi_sdo;
      o_spi_sck = 1'b1;
      tick(5);
      o_spi_sck = 1'b0;
    end
    tick(5);
    o_spi_csb_n = 1'b1;
    o_spi_sdi   = ~o_spi_sdi;  // Released line must not hold the last bit
    tick(8);
  endtask
endmodule

/* File: srv_regs_monitor.sv */
// Port checker for the register slice.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module srv_regs_monitor import srv_pkg::*; (
  input wire logic          i_clk_sys,
  input wire logic          i_rst_n,
  input wire logic          i_amplitude_cal_enable,
  input wire logic          i_frequency_cal_write,
  input wire logic          o_amplitude_override,
  input wire logic          o_capbank_override,
  input wire logic          o_amplitude_cal_run,
  input wire logic          o_frequency_cal_start,
  input srv_ref_path_t      o_ref_path,
  input wire logic          o_charge_pump_enable,
  input wire logic [1:0]    o_detector_mode,
  input wire logic          o_detector_single
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // Override output lags its bit by one cycle, so it is judged alongside the start
  start_follow_a: assert property (i_frequency_cal_write
    |=> o_frequency_cal_start == !o_capbank_override) else $error("calibration start wrong");
  start_cause_a: assert property (o_frequency_cal_start |-> $past(i_frequency_cal_write))
    else $error("calibration start without write");
  start_block_a: assert property (o_frequency_cal_start |-> !o_capbank_override)
    else $error("calibration start under override");
  amp_run_a: assert property (i_amplitude_cal_enable
    |=> o_amplitude_cal_run == !o_amplitude_override) else $error("amplitude calibration run wrong");
  amp_idle_a: assert property (!i_amplitude_cal_enable |=> !o_amplitude_cal_run)
    else $error("amplitude calibration without enable");
  amp_block_a: assert property (o_amplitude_cal_run |-> !o_amplitude_override)
    else $error("amplitude calibration under override");
  single_code_a: assert property (o_detector_single == (o_detector_mode == DETECTOR_SINGLE))
    else $error("detector single flag wrong");
  path_reset_a: assert property ($rose(i_rst_n) |-> ##3
    o_ref_path == {1'b0, 1'b1, 5'h01, 8'h01, 12'h001}) else $error("reference path reset value");
  pump_reset_a: assert property ($rose(i_rst_n) |-> ##3 o_charge_pump_enable
    && o_detector_mode == DETECTOR_DUAL) else $error("pump or detector reset value");
  ovr_reset_a: assert property ($rose(i_rst_n) |-> ##3 !o_amplitude_override && !o_capbank_override)
    else $error("override reset value");
  cover property (o_frequency_cal_start);
  cover property (i_amplitude_cal_enable && o_amplitude_override);
  cover property (o_detector_single);
  cover property (o_ref_path.reference_doubler_enable);
endmodule
bind srv_regs srv_regs_monitor u_mon (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_amplitude_cal_enable(i_amplitude_cal_enable),
  .i_frequency_cal_write(i_frequency_cal_write), .o_amplitude_override(o_amplitude_override),
  .o_capbank_override(o_capbank_override), .o_amplitude_cal_run(o_amplitude_cal_run),
  .o_frequency_cal_start(o_frequency_cal_start), .o_ref_path(o_ref_path),
  .o_charge_pump_enable(o_charge_pump_enable), .o_detector_mode(o_detector_mode),
  .o_detector_single(o_detector_single));

/* File: srv_regs_test.sv */
// Self-checking bench: host model frames, random field data, override checks.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ps
module srv_regs_test;
  import srv_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, amp_en = 1'b0, fcal_wr = 1'b0;
  logic csb_n, sck, sdi, sdo, amp_ov, cap_ov, amp_run, fcal_go, charge_pump_enable, single;
  logic [1:0] pd_mode;
  srv_ref_path_t path;
  logic [15:0] img [6];
  logic [15:0] rd, d, v;
  logic [31:0] seed = 32'hef0f;
  int bad_count = 0, compares = 0;
  localparam logic [15:0] MASK [6] = '{16'h2400, 16'h0a00, 16'h0f80, 16'h0ff0, 16'h0fff, 16'h4003};
  localparam logic [15:0] RST [6] = '{RST_VCO_OVERRIDE_CTRL, RST_REFERENCE_PATH_CTRL,
    RST_REFERENCE_MULTIPLIER_FACTOR_CFG, RST_REFERENCE_POST_CFG, RST_REFERENCE_PRE_CFG, RST_CHARGE_PUMP_CTRL};
  always #50 clk = ~clk;
  srv_regs DUT (.i_clk_sys(clk), .i_rst_n(rst_n), .i_spi_csb_n(csb_n), .i_spi_sck(sck),
    .i_spi_sdi(sdi), .o_spi_sdo(sdo), .i_amplitude_cal_enable(amp_en), .i_frequency_cal_write(fcal_wr),
    .o_amplitude_override(amp_ov), .o_capbank_override(cap_ov), .o_amplitude_cal_run(amp_run),
    .o_frequency_cal_start(fcal_go), .o_ref_path(path), .o_charge_pump_enable(charge_pump_enable),
    .o_detector_mode(pd_mode), .o_detector_single(single));
  srv_host_model host (.i_clk_sys(clk), .i_spi_sdo(sdo), .o_spi_csb_n(csb_n), .o_spi_sck(sck),
    .o_spi_sdi(sdi));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic srv_ref_path_t exp_path();
    return '{img[1][11], img[1][9], img[2][11:7], img[3][11:4], img[4][11:0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input int r, input logic [15:0] x);
    host.xfer(1'b0, OFF_VCO_OVERRIDE_CTRL + 7'(r), x, 24, rd);
    img[r] = x;
  endtask
  task automatic outs();
    check(32'(path), 32'(exp_path()));
    check(32'(charge_pump_enable), 32'(img[5][14]));
    check(32'(pd_mode), 32'(img[5][1:0]));
    check(32'(single), 32'(img[5][1:0] == DETECTOR_SINGLE));
    check(32'({amp_ov, cap_ov}), 32'({img[0][13], img[0][10]}));
    for (int r = 0; r < 6; r++) begin
      host.xfer(1'b1, OFF_VCO_OVERRIDE_CTRL + 7'(r), 16'h0000, 24, rd);
      check(32'(rd), 32'(img[r]));
    end
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    for (int r = 0; r < 6; r++) img[r] = RST[r];
  endtask
  task automatic conclude();
    $display("Compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #10_000_000;
    bad_count++;
    conclude();
  end
  initial begin
    do_reset();
    outs();
    $display("Test reset values done");
    for (int k = 0; k < 8; k++) begin
      for (int r = 0; r < 6; r++) begin
        seed = lfsr(seed);
        v = (k == 0) ? 16'h0000 : (k == 1) ? 16'hffff : seed[15:0];
        d = (RST[r] & ~MASK[r]) | (v & MASK[r]);
        if (r == 5 && k > 1) d[1:0] = {2{seed[20]}};
        wr(r, d);
      end
      outs();
    end
    $display("Test field values done");
    // Amplitude code and core select sit outside this slice
    amp_en = 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(0, {2'b00, k[0], 2'b00, k[1], 10'h000});
      check(32'(amp_run), 32'(!k[0]));
      fcal_wr = 1'b1;
      @(posedge clk);
      #1 fcal_wr = 1'b0;
      check(32'(fcal_go), 32'(!k[1]));
      @(posedge clk);
      #1;
      check(32'(fcal_go), 32'h0);
    end
    // Override cleared first so only the enable can hold the run low
    wr(0, 16'h0000);
    amp_en = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(32'(amp_run), 32'h0);
    $display("Test overrides done");
    host.xfer(1'b0, OFF_CHARGE_PUMP_CTRL, 16'h0000, 23, rd);
    host.xfer(1'b0, 7'h0e, 16'hffff, 24, rd);
    host.xfer(1'b1, OFF_REFERENCE_PATH_CTRL, 16'h0000, 24, rd);
    outs();
    $display("Test ignored frames done");
    do_reset();
    outs();
    $display("Test second reset done");
    conclude();
  end
endmodule
